// *** common/dhp_pkg.sv ***
// Shared constants and carrier types for the dual-channel host bus port
package dhp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;

  // ----------------------------------------------------------------
  // Encodings and values after reset
  // ----------------------------------------------------------------
  localparam logic              STYLE_STROBE = 1'b1;   // Separate read/write strobes
  localparam logic              STYLE_RW     = 1'b0;   // Chip select plus direction line
  localparam logic              CHAN_A       = 1'b0;
  localparam logic              CHAN_B       = 1'b1;
  localparam logic              RW_READ      = 1'b1;   // Direction line level for a read
  localparam logic              PREV_RST     = 1'b1;   // Treat a cycle as already seen
  localparam logic [DATA_W-1:0] DATA_RST     = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST     = 3'h0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // Request toward the two channel register files
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic              chan;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dhp_reg_req_t;

  localparam dhp_reg_req_t REQ_RST = '0;

  // Per-channel status and interrupt pin group
  typedef struct packed {
    logic irq;
    logic irq_oe;
    logic out2_n;
    logic tx_rdy_n;
    logic rx_rdy_n;
  } dhp_pin_out_t;

  localparam dhp_pin_out_t PIN_RST = '{irq: 1'b0, irq_oe: 1'b0, out2_n: 1'b1,
                                       tx_rdy_n: 1'b1, rx_rdy_n: 1'b1};

  // Bus cycle sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RD_ISSUE,
    ST_RD_HOLD,
    ST_WR_HOLD
  } dhp_state_t;

endpackage

// *** hdl/dhp_chan_pins.sv ***
// Per-channel interrupt, user output and ready pin driver
`timescale 1ns/1ps
module dhp_chan_pins (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Configuration
  input  wire logic          open_drain_i,
  input  wire logic          out2_bit_i,
  // Channel state
  input  wire logic          irq_req_i,
  input  wire logic          irq_any_i,
  input  wire logic          tx_space_i,
  input  wire logic          rx_avail_i,
  // Pins
  output dhp_pkg::dhp_pin_out_t pins_o
);

  dhp_pkg::dhp_pin_out_t pins_reg;
  dhp_pkg::dhp_pin_out_t pins_next;

  // Next pin state
  always_comb begin
    pins_next          = pins_reg;
    pins_next.out2_n   = ~out2_bit_i;
    pins_next.tx_rdy_n = ~tx_space_i;
    pins_next.rx_rdy_n = ~rx_avail_i;
    if (open_drain_i) begin
      pins_next.irq    = 1'b0;
      pins_next.irq_oe = irq_any_i;
    end else begin
      pins_next.irq    = irq_req_i;
      pins_next.irq_oe = out2_bit_i;
    end
  end

  // Pin registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_reg <= dhp_pkg::PIN_RST;
    end else begin
      pins_reg <= pins_next;
    end
  end

  assign pins_o = pins_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_OUT2_ON: assert property (@(posedge clk_i) disable iff (rst_i)
    (!open_drain_i && out2_bit_i) |=> (pins_o.irq_oe && !pins_o.out2_n
                                       && pins_o.irq == $past(irq_req_i)))
    else $error("Interrupt not driven with out2 set");

  AST_OUT2_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    (!open_drain_i && !out2_bit_i) |=> (!pins_o.irq_oe && pins_o.out2_n))
    else $error("Interrupt driven with out2 clear");

  AST_OPEN_DRAIN: assert property (@(posedge clk_i) disable iff (rst_i)
    open_drain_i |=> (!pins_o.irq && pins_o.irq_oe == $past(irq_any_i)))
    else $error("Open drain interrupt drove high or missed");

  AST_READY: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (pins_o.tx_rdy_n != $past(tx_space_i)) && (pins_o.rx_rdy_n != $past(rx_avail_i)))
    else $error("Ready outputs do not follow channel state");

endmodule

// *** hdl/dhp_host_port.sv ***
// Host bus port of a two-channel serial controller: strobe and rw styles
`timescale 1ns/1ps

module dhp_host_port (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // Bus style select
  input  wire logic                         bus_style_i,
  // Host bus pins
  input  wire logic                         read_strobe_n_i,
  input  wire logic                         write_strobe_n_i,
  input  wire logic                         chan_a_select_n_i,
  input  wire logic                         chan_b_select_n_i,
  input  wire logic [dhp_pkg::ADDR_W-1:0]   register_address_i,
  input  wire logic [dhp_pkg::DATA_W-1:0]   host_data_bus_i,
  output      logic [dhp_pkg::DATA_W-1:0]   host_data_bus_o,
  output      logic                         host_data_bus_oe_o,
  // Channel register access
  output dhp_pkg::dhp_reg_req_t             reg_req_o,
  input  wire logic [dhp_pkg::DATA_W-1:0]   chan_a_rdata_i,
  input  wire logic [dhp_pkg::DATA_W-1:0]   chan_b_rdata_i,
  // Channel state
  input  wire logic                         chan_a_out2_control_bit_i,
  input  wire logic                         chan_b_out2_control_bit_i,
  input  wire logic                         chan_a_irq_req_i,
  input  wire logic                         chan_b_irq_req_i,
  input  wire logic                         chan_a_tx_space_i,
  input  wire logic                         chan_b_tx_space_i,
  input  wire logic                         chan_a_rx_avail_i,
  input  wire logic                         chan_b_rx_avail_i,
  // Interrupt and user output pins
  output      logic                         chan_a_irq_out_o,
  output      logic                         chan_a_irq_out_oe_o,
  output      logic                         chan_b_irq_out_o,
  output      logic                         chan_b_irq_out_oe_o,
  output      logic                         chan_a_user_out2_n_o,
  output      logic                         chan_b_user_out2_n_o,
  // Ready pins
  output      logic                         chan_a_tx_ready_n_o,
  output      logic                         chan_a_rx_ready_n_o,
  output      logic                         chan_b_tx_ready_n_o,
  output      logic                         chan_b_rx_ready_n_o
);

  // ----------------------------------------------------------------
  // Cycle decode
  // ----------------------------------------------------------------
  logic strobe_style;
  logic cyc_rd_act;
  logic cyc_wr_act;
  logic start_chan;
  logic start_rd;
  logic start_wr;
  logic prev_rd_reg;
  logic prev_rd_next;
  logic prev_wr_reg;
  logic prev_wr_next;

  assign strobe_style = (bus_style_i == dhp_pkg::STYLE_STROBE);

  // Access levels per bus style; rw style never looks at the read strobe
  always_comb begin
    if (strobe_style) begin
      cyc_rd_act = !read_strobe_n_i
                   && (!chan_a_select_n_i || !chan_b_select_n_i);
      cyc_wr_act = !write_strobe_n_i
                   && (!chan_a_select_n_i || !chan_b_select_n_i);
      // Channel A wins when both selects are low
      start_chan = chan_a_select_n_i ? dhp_pkg::CHAN_B : dhp_pkg::CHAN_A;
    end else begin
      cyc_rd_act = !chan_a_select_n_i
                   && (write_strobe_n_i == dhp_pkg::RW_READ);
      cyc_wr_act = !chan_a_select_n_i
                   && (write_strobe_n_i != dhp_pkg::RW_READ);
      start_chan = chan_b_select_n_i;
    end
  end

  // Rising edges of the access levels; read wins a tie
  assign start_rd = cyc_rd_act && !prev_rd_reg;
  assign start_wr = cyc_wr_act && !prev_wr_reg && !start_rd;

  // Previous access levels
  always_comb begin
    prev_rd_next = cyc_rd_act;
    prev_wr_next = cyc_wr_act;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_rd_reg <= dhp_pkg::PREV_RST;
      prev_wr_reg <= dhp_pkg::PREV_RST;
    end else begin
      prev_rd_reg <= prev_rd_next;
      prev_wr_reg <= prev_wr_next;
    end
  end

  // ----------------------------------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------------------------------
  dhp_pkg::dhp_state_t                state_reg;
  dhp_pkg::dhp_state_t                state_next;
  dhp_pkg::dhp_reg_req_t              req_reg;
  dhp_pkg::dhp_reg_req_t              req_next;
  logic [dhp_pkg::DATA_W-1:0]         rdata_reg;
  logic [dhp_pkg::DATA_W-1:0]         rdata_next;
  logic [dhp_pkg::DATA_W-1:0]         hold_data_reg;
  logic [dhp_pkg::DATA_W-1:0]         hold_data_next;
  logic [dhp_pkg::ADDR_W-1:0]         hold_addr_reg;
  logic [dhp_pkg::ADDR_W-1:0]         hold_addr_next;
  logic                               hold_chan_reg;
  logic                               hold_chan_next;

  // Next state, request and captured bytes
  always_comb begin
    state_next     = state_reg;
    req_next       = req_reg;
    req_next.rd    = 1'b0;
    req_next.wr    = 1'b0;
    rdata_next     = rdata_reg;
    hold_data_next = hold_data_reg;
    hold_addr_next = hold_addr_reg;
    hold_chan_next = hold_chan_reg;
    case (state_reg)
      dhp_pkg::ST_IDLE: begin
        if (start_rd) begin
          // One-cycle read request with the address seen at the edge
          req_next.rd   = 1'b1;
          req_next.chan = start_chan;
          req_next.addr = register_address_i;
          state_next    = dhp_pkg::ST_RD_ISSUE;
        end else if (start_wr) begin
          hold_chan_next = start_chan;
          hold_addr_next = register_address_i;
          hold_data_next = host_data_bus_i;
          state_next     = dhp_pkg::ST_WR_HOLD;
        end
      end
      dhp_pkg::ST_RD_ISSUE: begin
        // Channel answers while the request is high
        rdata_next = (req_reg.chan == dhp_pkg::CHAN_B) ? chan_b_rdata_i
                                                       : chan_a_rdata_i;
        state_next = cyc_rd_act ? dhp_pkg::ST_RD_HOLD : dhp_pkg::ST_IDLE;
      end
      dhp_pkg::ST_RD_HOLD: begin
        if (!cyc_rd_act) begin
          state_next = dhp_pkg::ST_IDLE;
        end
      end
      dhp_pkg::ST_WR_HOLD: begin
        if (cyc_wr_act) begin
          // Track the bus up to the closing edge
          hold_data_next = host_data_bus_i;
          hold_addr_next = register_address_i;
        end else begin
          req_next.wr    = 1'b1;
          req_next.chan  = hold_chan_reg;
          req_next.addr  = hold_addr_reg;
          req_next.wdata = hold_data_reg;
          state_next     = dhp_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = dhp_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg     <= dhp_pkg::ST_IDLE;
      req_reg       <= dhp_pkg::REQ_RST;
      rdata_reg     <= dhp_pkg::DATA_RST;
      hold_data_reg <= dhp_pkg::DATA_RST;
      hold_addr_reg <= dhp_pkg::ADDR_RST;
      hold_chan_reg <= dhp_pkg::CHAN_A;
    end else begin
      state_reg     <= state_next;
      req_reg       <= req_next;
      rdata_reg     <= rdata_next;
      hold_data_reg <= hold_data_next;
      hold_addr_reg <= hold_addr_next;
      hold_chan_reg <= hold_chan_next;
    end
  end

  // Drive the bus only while the read is still held
  assign reg_req_o          = req_reg;
  assign host_data_bus_o    = rdata_reg;
  assign host_data_bus_oe_o = (state_reg == dhp_pkg::ST_RD_HOLD) && cyc_rd_act;

  // ----------------------------------------------------------------
  // Interrupt, user output and ready pins
  // ----------------------------------------------------------------
  dhp_pkg::dhp_pin_out_t pins_a;
  dhp_pkg::dhp_pin_out_t pins_b;
  logic                  irq_any;

  assign irq_any = chan_a_irq_req_i || chan_b_irq_req_i;

  dhp_chan_pins u_pins_a (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .open_drain_i (!strobe_style),
    .out2_bit_i   (chan_a_out2_control_bit_i),
    .irq_req_i    (chan_a_irq_req_i),
    .irq_any_i    (irq_any),
    .tx_space_i   (chan_a_tx_space_i),
    .rx_avail_i   (chan_a_rx_avail_i),
    .pins_o       (pins_a)
  );

  dhp_chan_pins u_pins_b (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .open_drain_i (1'b0),
    .out2_bit_i   (chan_b_out2_control_bit_i),
    .irq_req_i    (chan_b_irq_req_i),
    .irq_any_i    (1'b0),
    .tx_space_i   (chan_b_tx_space_i),
    .rx_avail_i   (chan_b_rx_avail_i),
    .pins_o       (pins_b)
  );

  // Pin groups onto ports
  assign chan_a_irq_out_o     = pins_a.irq;
  assign chan_a_irq_out_oe_o  = pins_a.irq_oe;
  assign chan_b_irq_out_o     = pins_b.irq;
  assign chan_b_irq_out_oe_o  = pins_b.irq_oe;
  assign chan_a_user_out2_n_o = pins_a.out2_n;
  assign chan_b_user_out2_n_o = pins_b.out2_n;
  assign chan_a_tx_ready_n_o  = pins_a.tx_rdy_n;
  assign chan_a_rx_ready_n_o  = pins_a.rx_rdy_n;
  assign chan_b_tx_ready_n_o  = pins_b.tx_rdy_n;
  assign chan_b_rx_ready_n_o  = pins_b.rx_rdy_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seq_rd_edge;
    (state_reg == dhp_pkg::ST_IDLE) && start_rd;
  endsequence

  sequence seq_rd_request;
    reg_req_o.rd ##1 !reg_req_o.rd;
  endsequence

  AST_RD_START: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_rd_edge |=> seq_rd_request and (reg_req_o.addr == $past(register_address_i)))
    else $error("Read edge did not issue one read request");

  AST_RD_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i)
    (seq_rd_edge ##1 cyc_rd_act ##1 cyc_rd_act) |-> host_data_bus_oe_o
      && host_data_bus_o == $past((reg_req_o.chan == dhp_pkg::CHAN_B) ? chan_b_rdata_i
                                                                        : chan_a_rdata_i))
    else $error("Read byte not driven while strobe held");

  AST_WR_COMMIT: assert property (@(posedge clk_i) disable iff (rst_i)
    ((state_reg == dhp_pkg::ST_WR_HOLD) && !cyc_wr_act)
      |=> reg_req_o.wr && reg_req_o.wdata == $past(host_data_bus_i, 2)
          && reg_req_o.addr == $past(register_address_i, 2))
    else $error("Write not committed at strobe rise");

  AST_WR_NO_EARLY: assert property (@(posedge clk_i) disable iff (rst_i)
    ((state_reg == dhp_pkg::ST_IDLE) && start_wr) |=> !reg_req_o.wr ##1
      (state_reg == dhp_pkg::ST_WR_HOLD || reg_req_o.wr))
    else $error("Write cycle start mishandled");

  AST_RW_IGNORE: assert property (@(posedge clk_i) disable iff (rst_i)
    (!strobe_style && chan_a_select_n_i) |-> !start_rd && !start_wr)
    else $error("Rw style cycle started without device select");

  AST_RW_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
    (!strobe_style && (state_reg == dhp_pkg::ST_IDLE) && !chan_a_select_n_i
     && !prev_rd_reg && !prev_wr_reg && !write_strobe_n_i)
      |=> (state_reg == dhp_pkg::ST_WR_HOLD))
    else $error("Direction line low did not start a write");

  AST_CHAN_A: assert property (@(posedge clk_i) disable iff (rst_i)
    (seq_rd_edge and (strobe_style && !chan_a_select_n_i))
      |=> reg_req_o.chan == dhp_pkg::CHAN_A)
    else $error("Select A did not pick channel A");

  AST_CHAN_B: assert property (@(posedge clk_i) disable iff (rst_i)
    (seq_rd_edge and (strobe_style && chan_a_select_n_i && !chan_b_select_n_i))
      |=> reg_req_o.chan == dhp_pkg::CHAN_B)
    else $error("Select B did not pick channel B");

  AST_RW_CHAN: assert property (@(posedge clk_i) disable iff (rst_i)
    (seq_rd_edge and !strobe_style) |=> reg_req_o.chan == $past(chan_b_select_n_i))
    else $error("Channel address bit not honoured");

  AST_BUS_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    (!cyc_rd_act || state_reg != dhp_pkg::ST_RD_HOLD) |-> !host_data_bus_oe_o)
    else $error("Data bus driven with no read in progress");

endmodule

// *** tb/dhp_host_model.sv ***
// Host processor model driving the parallel bus of the host port
`timescale 1ns/1ps
module dhp_host_model (
  // Clock
  input  wire logic       clk_i,
  // Device side of the data bus
  input  wire logic [7:0] dev_data_i,
  input  wire logic       dev_oe_i,
  // Host bus pins
  output      logic       bus_style_o,
  output      logic       read_strobe_n_o,
  output      logic       write_strobe_n_o,
  output      logic       chan_a_select_n_o,
  output      logic       chan_b_select_n_o,
  output      logic [2:0] register_address_o,
  output      logic [7:0] bus_level_o
);
  logic [7:0] drv_data   = 8'h00;
  logic       drv_en     = 1'b0;
  logic [7:0] last_level = 8'h00;

  // ----------------------------------------------------------------
  // Bus resolution
  // ----------------------------------------------------------------
  // Released bus has no pull, so show the inverse of the last level
  assign bus_level_o = dev_oe_i ? dev_data_i : (drv_en ? drv_data : ~last_level);
  always @(posedge clk_i) last_level <= bus_level_o;

  initial begin
    bus_style_o        = dhp_pkg::STYLE_STROBE;
    read_strobe_n_o    = 1'b1;
    write_strobe_n_o   = 1'b1;
    chan_a_select_n_o  = 1'b1;
    chan_b_select_n_o  = 1'b1;
    register_address_o = 3'h0;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Style changes only while the bus is quiet
  task automatic set_style(input logic s);
    @(posedge clk_i);
    bus_style_o <= s;
    repeat (2) @(posedge clk_i);
  endtask

  // One byte access; the access stays active for hold plus one cycles
  task automatic access(input logic wr, input logic chan, input logic sel,
                        input logic [2:0] addr, input logic [7:0] wdata, input int hold,
                        output logic [7:0] rdata, output logic oe_seen);
    @(posedge clk_i);
    register_address_o <= addr;
    drv_data <= wdata;
    drv_en <= wr;
    if (bus_style_o == dhp_pkg::STYLE_STROBE) begin
      read_strobe_n_o <= wr;
      write_strobe_n_o <= !wr;
      chan_a_select_n_o <= !(sel && !chan);
      chan_b_select_n_o <= !(sel && chan);
    end else begin
      read_strobe_n_o <= 1'b1;
      write_strobe_n_o <= !wr;
      chan_a_select_n_o <= !sel;
      chan_b_select_n_o <= chan;
    end
    repeat (hold) @(posedge clk_i);
    #1;
    rdata = bus_level_o;
    oe_seen = dev_oe_i;
    @(posedge clk_i);
    read_strobe_n_o <= 1'b1;
    write_strobe_n_o <= 1'b1;
    chan_a_select_n_o <= 1'b1;
    chan_b_select_n_o <= 1'b1;
    drv_en <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
endmodule

// *** tb/tb_dhp_host_port.sv ***
// Self-checking bench for the dual-channel host bus port
`timescale 1ns/1ps
module tb_dhp_host_port;
  logic                  clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  logic                  style, rd_n, wr_n, sel_a_n, sel_b_n, oe, oes;
  logic [2:0]            addr;
  logic [7:0]            bus, dout, a_rdata, b_rdata, rd, wv;
  logic [7:0]            pin_in = 8'h00;
  logic [7:0]            regs [2][8];
  logic                  a_irq, a_oe, b_irq, b_oe, a_o2, b_o2, a_tx, a_rx, b_tx, b_rx;
  dhp_pkg::dhp_reg_req_t reg_req;
  int                    error_cnt = 0;
  int                    checks = 0;

  // Clock at 125 MHz
  always #4 clk_i = ~clk_i;

  // Channel register files answering the port's requests
  initial for (int i = 0; i < 16; i++) regs[i/8][i%8] = 8'h00;
  always @(posedge clk_i) begin
    if (reg_req.wr === 1'b1) begin
      regs[reg_req.chan][reg_req.addr] <= reg_req.wdata;
    end
  end
  assign a_rdata = regs[0][reg_req.addr];
  assign b_rdata = regs[1][reg_req.addr];

  dhp_host_model host_u (
    .clk_i(clk_i), .dev_data_i(dout), .dev_oe_i(oe), .bus_style_o(style),
    .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n), .chan_a_select_n_o(sel_a_n),
    .chan_b_select_n_o(sel_b_n), .register_address_o(addr), .bus_level_o(bus)
  );

  dhp_host_port dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .bus_style_i(style), .read_strobe_n_i(rd_n),
    .write_strobe_n_i(wr_n), .chan_a_select_n_i(sel_a_n), .chan_b_select_n_i(sel_b_n),
    .register_address_i(addr), .host_data_bus_i(bus), .host_data_bus_o(dout),
    .host_data_bus_oe_o(oe), .reg_req_o(reg_req), .chan_a_rdata_i(a_rdata),
    .chan_b_rdata_i(b_rdata), .chan_a_out2_control_bit_i(pin_in[0]),
    .chan_b_out2_control_bit_i(pin_in[1]), .chan_a_irq_req_i(pin_in[2]),
    .chan_b_irq_req_i(pin_in[3]), .chan_a_tx_space_i(pin_in[4]),
    .chan_b_tx_space_i(pin_in[5]), .chan_a_rx_avail_i(pin_in[6]),
    .chan_b_rx_avail_i(pin_in[7]), .chan_a_irq_out_o(a_irq), .chan_a_irq_out_oe_o(a_oe),
    .chan_b_irq_out_o(b_irq), .chan_b_irq_out_oe_o(b_oe), .chan_a_user_out2_n_o(a_o2),
    .chan_b_user_out2_n_o(b_o2), .chan_a_tx_ready_n_o(a_tx), .chan_a_rx_ready_n_o(a_rx),
    .chan_b_tx_ready_n_o(b_tx), .chan_b_rx_ready_n_o(b_rx)
  );

  // ----------------------------------------------------------------
  // Compare and closing report
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check("data enable after reset", {7'h0, oe}, 8'h00);
    check("out2 b after reset", {7'h0, b_o2}, 8'h01);
    // Fill and read back every register of both channels, both styles
    for (int s = 1; s >= 0; s--) begin
      host_u.set_style(s[0]);
      for (int i = 0; i < 16; i++) begin
        wv = {s[0], i[3], 3'h0, i[2:0]} ^ 8'ha5;
        host_u.access(1'b1, i[3], 1'b1, i[2:0], wv, 3, rd, oes);
      end
      for (int i = 0; i < 16; i++) begin
        wv = {s[0], i[3], 3'h0, i[2:0]} ^ 8'ha5;
        host_u.access(1'b0, i[3], 1'b1, i[2:0], 8'h00, 4, rd, oes);
        check("read data", rd, wv);
        check("data enable in read", {7'h0, oes}, 8'h01);
        check("data enable after read", {7'h0, oe}, 8'h00);
      end
      // Access without any select leaves the register alone
      host_u.access(1'b1, 1'b0, 1'b0, 3'h2, 8'h3c, 3, rd, oes);
      host_u.access(1'b0, 1'b0, 1'b0, 3'h2, 8'h00, 4, rd, oes);
      check("unselected read enable", {7'h0, oes}, 8'h00);
      wv = {s[0], 1'b0, 6'h02} ^ 8'ha5;
      host_u.access(1'b0, 1'b0, 1'b1, 3'h2, 8'h00, 4, rd, oes);
      check("unselected write", rd, wv);
    end
    // Every combination of pin inputs in both styles
    for (int i = 0; i < 512; i++) begin
      if (i == 0 || i == 256) host_u.set_style(i[8]);
      @(posedge clk_i);
      pin_in <= i[7:0];
      repeat (2) @(posedge clk_i);
      #1;
      if (i[8]) check("irq a", {6'h0, a_irq, a_oe}, {6'h0, i[2], i[0]});
      else check("irq a", {6'h0, a_irq, a_oe}, {6'h0, 1'b0, i[2] | i[3]});
      check("irq b", {6'h0, b_irq, b_oe}, {6'h0, i[3], i[1]});
      check("out2", {6'h0, a_o2, b_o2}, {6'h0, ~i[0], ~i[1]});
      check("ready", {4'h0, a_tx, a_rx, b_tx, b_rx},
            {4'h0, ~i[4], ~i[6], ~i[5], ~i[7]});
    end
    conclude();
  end
endmodule
